/* conv_pkg.sv */
/*
 conv_pkg: shared constants and types of the simultaneous-sample
 converter sequencer and of its host controller.
 Assumes both ends run on one clock core_clk at 10 MHz.
*/
package conv_pkg;
	localparam int SAMPLE_W = 11;
	localparam int BUS_W = 12;
	localparam int CHANNELS = 4;
	localparam int AUX_INPUTS = 4;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int IRQ_W = 2;
	localparam int CLK_PERIOD_NS = 100;
	// acquisition, per-channel conversion and approximation steps
	localparam logic [5:0] ACQ_CYCLES = 6'h14;
	localparam logic [5:0] CONV_CYCLES = 6'h28;
	localparam logic [5:0] SAR_STEPS = 6'h0b;
	localparam logic [5:0] CNT_ONE = 6'h01;
	// host side pin timing
	localparam logic [1:0] TRIGGER_CYCLES = 2'h2;
	localparam logic [1:0] READ_CYCLES = 2'h3;
	// result register addresses on the result select pins
	localparam logic [1:0] CH_ONE = 2'h0;
	localparam logic [1:0] CH_TWO = 2'h1;
	localparam logic [1:0] CH_THREE = 2'h2;
	localparam logic [1:0] CH_AUX = 2'h3;
	// host register offsets
	localparam logic [7:0] REG_CONTROL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
	localparam logic [7:0] REG_IRQ_CLEAR = 8'h0c;
	localparam logic [7:0] REG_IRQ_ENABLE = 8'h10;
	localparam logic [7:0] REG_RESULT_SEL = 8'h14;
	localparam logic [7:0] REG_RESULT = 8'h18;
	// field positions
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_CHIP_RESET_BIT = 1;
	localparam int CTRL_MODE_LSB = 4;
	localparam int CTRL_AUX_LSB = 8;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_READING_BIT = 1;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_READ_BIT = 1;
	// values after reset
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [1:0] AUX_RESET = 2'h0;
	localparam logic [1:0] IRQ_RESET = 2'h0;
	localparam logic [2:0] TRIG_SYNC_RESET = 3'h0;
	localparam logic [2:0] RSTN_SYNC_RESET = 3'h7;

	typedef enum logic [1:0] {
		MODE_TWO_THREE = 2'b00,
		MODE_TWO_THREE_AUX = 2'b01,
		MODE_ONE_TO_THREE = 2'b10,
		MODE_ALL = 2'b11
	} group_mode_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ACQ = 2'b01,
		ST_CONV = 2'b10
	} seq_state_t;
endpackage

/* conv_link.sv */
/*
 conv_link: pins between the converter sequencer and its host.
 Assumes both ends share core_clk; the data pins are three-state and
 read as zero while the converter does not drive them.
*/
`timescale 1ns/1ps
interface conv_link;
	logic sample_trigger_in;
	logic group_select_lo;
	logic group_select_hi;
	logic aux_input_select_lo;
	logic aux_input_select_hi;
	logic result_select_lo;
	logic result_select_hi;
	logic chip_select_n;
	logic read_n;
	logic reset_n;
	logic busy_n;
	logic [conv_pkg::BUS_W-1:0] data_out;
	logic data_oe;
	wire logic [conv_pkg::BUS_W-1:0] data_bus;

	// wire level of the data pins
	assign data_bus = data_oe ? data_out : 12'h000;

	modport device (
		input sample_trigger_in,
		input group_select_lo,
		input group_select_hi,
		input aux_input_select_lo,
		input aux_input_select_hi,
		input result_select_lo,
		input result_select_hi,
		input chip_select_n,
		input read_n,
		input reset_n,
		output busy_n,
		output data_out,
		output data_oe
	);

	modport host (
		output sample_trigger_in,
		output group_select_lo,
		output group_select_hi,
		output aux_input_select_lo,
		output aux_input_select_hi,
		output result_select_lo,
		output result_select_hi,
		output chip_select_n,
		output read_n,
		output reset_n,
		input busy_n,
		input data_bus
	);
endinterface

/* conv_device.sv */
/*
 conv_device: sequencer of a four-way simultaneous-sample successive
 approximation converter with double-buffered parallel results.
 Assumes analog levels arrive as unsigned 11-bit codes, the trigger and
 chip reset pins may be asynchronous, and the other pins come from
 logic on core_clk.
*/
`timescale 1ns/1ps
// Function
// RULE1: eleven-bit twos complement results by approximation
// RULE2: twelve-bit output, bit zero low, MSB top
// RULE3: forty clock cycles per converted channel
// RULE4: acquisition lasts twenty cycles for any group
// RULE5: hold four channels together, convert in turn
// RULE6: acquisition then conversions back to back
// RULE7: host supplies clock within permitted range
// RULE8: busy output shows sequence in progress
// RULE9: host drives two group select pins
// RULE10: host drives two auxiliary select pins
// RULE11: host drives two result select pins
// RULE12: busy low from start until buffers updated
// RULE13: start on first edge after trigger high; the code starts on the fifth edge, after synchronizing and filtering the pin
// RULE14: group select decodes to channel sets
// RULE15: result select picks result during read
// RULE16: chip reset aborts sequence, clears busy
// RULE17: results double buffered, updated together
module conv_device (
	input wire logic core_clk,
	input wire logic rst,
	conv_link.device link,
	input wire logic [conv_pkg::SAMPLE_W-1:0] analog_input_one,
	input wire logic [conv_pkg::SAMPLE_W-1:0] analog_input_two,
	input wire logic [conv_pkg::SAMPLE_W-1:0] analog_input_three,
	input wire logic [conv_pkg::AUX_INPUTS-1:0][conv_pkg::SAMPLE_W-1:0]
		aux_inputs
);
	import conv_pkg::*;

	logic [2:0] trig_sync;
	logic [2:0] rstn_sync;
	logic trig_level;
	logic trig_prev;
	logic rstn_level;
	logic chip_reset;
	logic abort;
	logic start_seen;
	seq_state_t state;
	logic [5:0] cnt;
	logic [1:0] chan;
	group_mode_t mode;
	logic [1:0] aux_sel;
	logic [SAMPLE_W-1:0] held [CHANNELS];
	logic [SAMPLE_W-1:0] trial;
	logic [SAMPLE_W-1:0] shadow [CHANNELS];
	logic [SAMPLE_W-1:0] result [CHANNELS];
	logic acq_done;
	logic last_step;
	logic seq_done;
	logic reading;
	logic [1:0] read_sel;

	function automatic logic [1:0] first_channel(input group_mode_t m);
		return m[1] ? CH_ONE : CH_TWO;
	endfunction

	function automatic logic [1:0] last_channel(input group_mode_t m);
		return m[0] ? CH_AUX : CH_THREE;
	endfunction

	// one approximation step: try the next bit, keep it if not above
	function automatic logic [SAMPLE_W-1:0] sar_step(
		input logic [SAMPLE_W-1:0] base,
		input logic [5:0] step,
		input logic [SAMPLE_W-1:0] level
	);
		logic [3:0] pos;
		logic [SAMPLE_W-1:0] probe;
		pos = 4'(SAR_STEPS - CNT_ONE - step);
		probe = base | ({{(SAMPLE_W-1){1'b0}}, 1'b1} << pos);
		return (probe <= level) ? probe : base;
	endfunction

	// offset binary to twos complement
	function automatic logic [SAMPLE_W-1:0] to_twos(
		input logic [SAMPLE_W-1:0] code
	);
		return {~code[SAMPLE_W-1], code[SAMPLE_W-2:0]};
	endfunction

	// trigger and chip reset pins cross in
	always_ff @(posedge core_clk) begin
		if (rst) begin
			trig_sync <= TRIG_SYNC_RESET;
			rstn_sync <= RSTN_SYNC_RESET;
		end else begin
			trig_sync <= {trig_sync[1:0], link.sample_trigger_in};
			rstn_sync <= {rstn_sync[1:0], link.reset_n};
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			trig_level <= 1'b0;
			rstn_level <= 1'b1;
			trig_prev <= 1'b0;
		end else begin
			if (trig_sync[2] == trig_sync[1]) begin
				trig_level <= trig_sync[2];
			end
			if (rstn_sync[2] == rstn_sync[1]) begin
				rstn_level <= rstn_sync[2];
			end
			trig_prev <= trig_level;
		end
	end

	assign chip_reset = ~rstn_level;
	assign abort = rst | chip_reset; // RULE16
	assign start_seen = trig_level & ~trig_prev & (state == ST_IDLE); // RULE13
	assign acq_done = (cnt == ACQ_CYCLES - CNT_ONE); // RULE4
	assign last_step = (cnt == CONV_CYCLES - CNT_ONE); // RULE3
	assign seq_done = (state == ST_CONV) && last_step &&
		(chan == last_channel(mode)); // RULE6

	// sequencer
	always_ff @(posedge core_clk) begin
		if (abort) begin
			state <= ST_IDLE; // RULE16
			cnt <= 6'h00;
			chan <= CH_ONE;
		end else begin
			case (state)
				ST_IDLE: begin
					cnt <= 6'h00;
					if (start_seen) begin
						state <= ST_ACQ; // RULE13
					end
				end
				ST_ACQ: begin
					if (acq_done) begin
						state <= ST_CONV; // RULE6
						cnt <= 6'h00;
						chan <= first_channel(mode); // RULE14
					end else begin
						cnt <= cnt + CNT_ONE; // RULE4
					end
				end
				ST_CONV: begin
					if (last_step) begin
						cnt <= 6'h00;
						if (chan == last_channel(mode)) begin
							state <= ST_IDLE; // RULE14
						end else begin
							chan <= chan + 2'h1; // RULE6
						end
					end else begin
						cnt <= cnt + CNT_ONE; // RULE3
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// group and auxiliary choice, taken at the start
	always_ff @(posedge core_clk) begin
		if (abort) begin
			mode <= group_mode_t'(MODE_RESET);
			aux_sel <= AUX_RESET;
		end else if (start_seen) begin
			mode <= group_mode_t'({link.group_select_hi,
				link.group_select_lo}); // RULE14
			aux_sel <= {link.aux_input_select_hi,
				link.aux_input_select_lo};
		end
	end

	// all four channels held at the same edge
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < CHANNELS; i++) begin
				held[i] <= '0;
			end
		end else if (state == ST_ACQ && acq_done) begin
			held[CH_ONE] <= analog_input_one; // RULE5
			held[CH_TWO] <= analog_input_two;
			held[CH_THREE] <= analog_input_three;
			held[CH_AUX] <= aux_inputs[aux_sel];
		end
	end

	// successive approximation of the current channel
	always_ff @(posedge core_clk) begin
		if (abort) begin
			trial <= '0;
		end else if (state != ST_CONV || last_step) begin
			trial <= '0;
		end else if (cnt < SAR_STEPS) begin
			trial <= sar_step(trial, cnt, held[chan]); // RULE1
		end
	end

	// shadow results filled per channel, shown all at once at the end
	always_ff @(posedge core_clk) begin
		if (abort) begin
			for (int i = 0; i < CHANNELS; i++) begin
				shadow[i] <= '0;
				result[i] <= '0;
			end
		end else if (state == ST_CONV && last_step) begin
			shadow[chan] <= to_twos(trial); // RULE1
			if (seq_done) begin
				for (int i = 0; i < CHANNELS; i++) begin
					result[i] <= (2'(i) == chan) ?
						to_twos(trial) : shadow[i]; // RULE17
				end
			end
		end
	end

	// busy, low for the whole sequence
	always_ff @(posedge core_clk) begin
		if (abort) begin
			link.busy_n <= 1'b1; // RULE16
		end else if (start_seen) begin
			link.busy_n <= 1'b0; // RULE12
		end else if (seq_done) begin
			link.busy_n <= 1'b1; // RULE8
		end
	end

	// parallel read port
	assign reading = ~link.chip_select_n & ~link.read_n;
	assign read_sel = {link.result_select_hi, link.result_select_lo};

	always_ff @(posedge core_clk) begin
		if (abort) begin
			link.data_oe <= 1'b0;
			link.data_out <= 12'h000;
		end else begin
			link.data_oe <= reading;
			if (reading) begin
				link.data_out <= {result[read_sel], 1'b0}; // RULE2 RULE15
			end else begin
				link.data_out <= 12'h000;
			end
		end
	end
endmodule

/* conv_host.sv */
/*
 conv_host: controller that starts conversions, chooses the group and
 auxiliary input, reads results and raises an interrupt.
 Assumes software on a plain strobe port and the converter on core_clk.
*/
`timescale 1ns/1ps
module conv_host (
	input wire logic core_clk,
	input wire logic rst,
	conv_link.host link,
	input wire logic [conv_pkg::ADDR_W-1:0] addr,
	input wire logic [conv_pkg::DATA_W-1:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [conv_pkg::DATA_W-1:0] rdata,
	output logic irq
);
	import conv_pkg::*;

	logic [1:0] ctrl_mode;
	logic [1:0] ctrl_aux;
	logic chip_reset_hold;
	logic pending;
	logic busy_prev_n;
	logic [1:0] trig_cnt;
	logic reading;
	logic [1:0] read_cnt;
	logic [1:0] read_sel;
	logic [BUS_W-1:0] result_data;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_enable;
	logic [IRQ_W-1:0] events;
	logic [IRQ_W-1:0] clear_mask;
	logic [IRQ_W-1:0] next_status;
	logic start_req;
	logic read_req;
	logic done_edge;
	logic read_done;

	assign start_req = wr_en && addr == REG_CONTROL &&
		wdata[CTRL_START_BIT] && !pending && !chip_reset_hold;
	assign read_req = wr_en && addr == REG_RESULT_SEL &&
		!reading && !chip_reset_hold;
	assign done_edge = pending && link.busy_n && !busy_prev_n;
	assign read_done = reading && read_cnt == 2'h0;

	// control register and the select pins it drives
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl_mode <= MODE_RESET;
			ctrl_aux <= AUX_RESET;
			chip_reset_hold <= 1'b0;
		end else if (wr_en && addr == REG_CONTROL) begin
			ctrl_mode <= wdata[CTRL_MODE_LSB +: 2];
			ctrl_aux <= wdata[CTRL_AUX_LSB +: 2];
			chip_reset_hold <= wdata[CTRL_CHIP_RESET_BIT];
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			link.group_select_lo <= 1'b0;
			link.group_select_hi <= 1'b0;
			link.aux_input_select_lo <= 1'b0;
			link.aux_input_select_hi <= 1'b0;
			link.reset_n <= 1'b0;
		end else begin
			link.group_select_lo <= ctrl_mode[0]; // RULE9
			link.group_select_hi <= ctrl_mode[1]; // RULE9
			link.aux_input_select_lo <= ctrl_aux[0]; // RULE10
			link.aux_input_select_hi <= ctrl_aux[1]; // RULE10
			link.reset_n <= ~chip_reset_hold;
		end
	end

	// trigger pulse, counted in cycles of the shared clock
	always_ff @(posedge core_clk) begin
		if (rst || chip_reset_hold) begin
			trig_cnt <= 2'h0;
			link.sample_trigger_in <= 1'b0;
		end else if (start_req) begin
			trig_cnt <= TRIGGER_CYCLES; // RULE7
			link.sample_trigger_in <= 1'b1;
		end else if (trig_cnt != 2'h0) begin
			trig_cnt <= trig_cnt - 2'h1;
			link.sample_trigger_in <= (trig_cnt != 2'h1);
		end
	end

	// conversion in flight until busy returns high
	always_ff @(posedge core_clk) begin
		if (rst || chip_reset_hold) begin
			pending <= 1'b0;
			busy_prev_n <= 1'b1;
		end else begin
			busy_prev_n <= link.busy_n;
			if (start_req) begin
				pending <= 1'b1;
			end else if (done_edge) begin
				pending <= 1'b0;
			end
		end
	end

	// result read over the parallel port
	always_ff @(posedge core_clk) begin
		if (rst || chip_reset_hold) begin
			reading <= 1'b0;
			read_cnt <= 2'h0;
			read_sel <= CH_ONE;
			link.chip_select_n <= 1'b1;
			link.read_n <= 1'b1;
			link.result_select_lo <= 1'b0;
			link.result_select_hi <= 1'b0;
		end else if (read_req) begin
			reading <= 1'b1;
			read_cnt <= READ_CYCLES - 2'h1;
			read_sel <= wdata[1:0];
			link.chip_select_n <= 1'b0;
			link.read_n <= 1'b0;
			link.result_select_lo <= wdata[0]; // RULE11
			link.result_select_hi <= wdata[1]; // RULE11
		end else if (read_done) begin
			reading <= 1'b0;
			link.chip_select_n <= 1'b1;
			link.read_n <= 1'b1;
		end else if (reading) begin
			read_cnt <= read_cnt - 2'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			result_data <= 12'h000;
		end else if (read_done) begin
			result_data <= link.data_bus;
		end
	end

	// interrupt status, set wins over clear
	assign events = {read_done, done_edge};
	assign clear_mask = (wr_en && addr == REG_IRQ_CLEAR) ?
		wdata[IRQ_W-1:0] : IRQ_RESET;
	assign next_status = (irq_status & ~clear_mask) | events;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_status <= IRQ_RESET;
			irq_enable <= IRQ_RESET;
			irq <= 1'b0;
		end else begin
			irq_status <= next_status;
			if (wr_en && addr == REG_IRQ_ENABLE) begin
				irq_enable <= wdata[IRQ_W-1:0];
			end
			irq <= |(irq_status & irq_enable);
		end
	end

	// read data stands in the cycle after the strobe only
	always_ff @(posedge core_clk) begin
		if (rst || !rd_en) begin
			rdata <= 32'h0000_0000;
		end else begin
			case (addr)
				REG_CONTROL: begin
					rdata <= (32'(ctrl_aux) << CTRL_AUX_LSB) |
						(32'(ctrl_mode) << CTRL_MODE_LSB) |
						(32'(chip_reset_hold) << CTRL_CHIP_RESET_BIT);
				end
				REG_STATUS: begin
					rdata <= (32'(reading) << STAT_READING_BIT) |
						(32'(pending) << STAT_BUSY_BIT);
				end
				REG_IRQ_STATUS: begin
					rdata <= 32'(irq_status);
				end
				REG_IRQ_ENABLE: begin
					rdata <= 32'(irq_enable);
				end
				REG_RESULT_SEL: begin
					rdata <= 32'(read_sel);
				end
				REG_RESULT: begin
					rdata <= 32'(result_data);
				end
				default: begin
					rdata <= 32'h0000_0000;
				end
			endcase
		end
	end
endmodule

/* conv_monitor.sv */
/*
 conv_monitor: timing checks on the pins between converter and host.
 Assumes it sees the link signals of one conv_link on core_clk.
*/
`timescale 1ns/1ps
module conv_monitor (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic sample_trigger_in,
	input wire logic group_select_lo,
	input wire logic group_select_hi,
	input wire logic result_select_lo,
	input wire logic result_select_hi,
	input wire logic chip_select_n,
	input wire logic read_n,
	input wire logic reset_n,
	input wire logic busy_n,
	input wire logic [conv_pkg::BUS_W-1:0] data_out,
	input wire logic data_oe
);
	import conv_pkg::*;
	int low_cnt;
	int hi_cnt;
	int trig_age;
	int exp_len;
	logic [1:0] mode_q;
	logic [1:0] sel;
	assign sel = {result_select_hi, result_select_lo};
	assign exp_len = int'(ACQ_CYCLES) + int'(CONV_CYCLES)
		* (2 + int'(mode_q[1]) + int'(mode_q[0]));
	// cycles busy has been low
	always_ff @(posedge core_clk) begin
		low_cnt <= (rst || busy_n) ? 0 : low_cnt + 1;
	end
	// cycles chip reset has been released
	always_ff @(posedge core_clk) begin
		if (rst || !reset_n) hi_cnt <= 0;
		else if (hi_cnt < 15) hi_cnt <= hi_cnt + 1;
	end
	// cycles since the trigger was last high
	always_ff @(posedge core_clk) begin
		if (rst || sample_trigger_in) trig_age <= 0;
		else if (trig_age < 15) trig_age <= trig_age + 1;
	end
	// group seen while idle
	always_ff @(posedge core_clk) begin
		if (rst) mode_q <= 2'h0;
		else if (busy_n) mode_q <= {group_select_hi, group_select_lo};
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	busy_len_a: assert property (
		$rose(busy_n) && hi_cnt > 8 |-> low_cnt == exp_len)
		else $error("busy low for the wrong number of cycles");
	no_early_a: assert property (
		!busy_n && reset_n && hi_cnt > 8 && low_cnt < exp_len - 1
		|=> !busy_n) else $error("busy ended early");
	start_taken_a: assert property (
		$rose(sample_trigger_in) && busy_n && hi_cnt > 8
		|-> ##[1:6] !busy_n) else $error("start not taken");
	fall_cause_a: assert property (
		$fell(busy_n) |-> trig_age < 6)
		else $error("busy fell with no trigger");
	abort_idle_a: assert property (
		!reset_n [*6] |-> busy_n && !data_oe)
		else $error("chip reset did not stop the device");
	bit_zero_a: assert property (
		data_oe |-> data_out[0] == 1'b0) else $error("data bit 0 high");
	read_on_a: assert property (
		!chip_select_n && !read_n && hi_cnt > 8 |=> data_oe)
		else $error("read not answered");
	read_off_a: assert property (
		chip_select_n && read_n |=> !data_oe)
		else $error("data driven with no read");
	hold_old_a: assert property (
		!busy_n && !$past(busy_n) && data_oe && $past(data_oe)
		&& sel == $past(sel) && $past(sel) == $past(sel, 2)
		|-> $stable(data_out)) else $error("result changed mid sequence");
endmodule

/* simultaneous_sample_conversion_sequencer_test.sv */
/*
 Testbench of converter and host joined by conv_link.
 Assumes core_clk at 10 MHz and the host register map of conv_pkg.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
	total_checks++; \
	if ((g) !== (e)) begin \
		bad_count++; \
		$display("wrong value %s exp %h got %h", nm, e, g); \
	end \
end
module simultaneous_sample_conversion_sequencer_test;
	import conv_pkg::*;
	typedef struct {
		logic [1:0] mode;
		logic [1:0] sel;
		logic [10:0] v1;
		logic [10:0] v2;
		logic [10:0] v3;
		logic [10:0] va;
		int len;
	} row_t;
	row_t rows [4] = '{
		'{2'h0, 2'h0, 11'h000, 11'h7ff, 11'h400, 11'h123, 100},
		'{2'h1, 2'h1, 11'h001, 11'h3ff, 11'h000, 11'h7ff, 140},
		'{2'h2, 2'h2, 11'h555, 11'h2aa, 11'h7fe, 11'h000, 140},
		'{2'h3, 2'h3, 11'h400, 11'h001, 11'h3fe, 11'h456, 180}};
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] addr = 8'h00;
	logic [DATA_W-1:0] wdata = 32'h0000_0000;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [DATA_W-1:0] rdata;
	logic irq;
	logic [SAMPLE_W-1:0] in1 = 11'h000;
	logic [SAMPLE_W-1:0] in2 = 11'h000;
	logic [SAMPLE_W-1:0] in3 = 11'h000;
	logic [AUX_INPUTS-1:0][SAMPLE_W-1:0] aux = 44'h000_0000_0000;
	logic [BUS_W-1:0] exp_w [4] = '{default: 12'h000};
	logic [DATA_W-1:0] v;
	int bad_count = 0;
	int total_checks = 0;
	int cnt = 0;
	int last_len = 0;
	conv_link link();
	conv_device u_conv_device(.core_clk(core_clk), .rst(rst),
		.link(link.device), .analog_input_one(in1),
		.analog_input_two(in2), .analog_input_three(in3),
		.aux_inputs(aux));
	conv_host u_conv_host(.core_clk(core_clk), .rst(rst),
		.link(link.host), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .irq(irq));
	conv_monitor u_conv_monitor(.core_clk(core_clk), .rst(rst),
		.sample_trigger_in(link.sample_trigger_in),
		.group_select_lo(link.group_select_lo),
		.group_select_hi(link.group_select_hi),
		.result_select_lo(link.result_select_lo),
		.result_select_hi(link.result_select_hi),
		.chip_select_n(link.chip_select_n), .read_n(link.read_n),
		.reset_n(link.reset_n), .busy_n(link.busy_n),
		.data_out(link.data_out), .data_oe(link.data_oe));
	initial begin
		forever #50 core_clk = ~core_clk;
	end
	// length of the last busy pulse
	always @(posedge core_clk) begin
		if (link.busy_n === 1'b0) cnt++;
		else if (cnt != 0) begin
			last_len = cnt;
			cnt = 0;
		end
	end
	function automatic logic [11:0] word(input logic [10:0] c);
		return {c ^ 11'h400, 1'h0};
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge core_clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge core_clk);
		rd_en <= 1'b0;
		@(negedge core_clk);
		d = rdata;
	endtask
	task automatic wait_busy(input logic lvl);
		int n = 0;
		while (link.busy_n !== lvl && n < 400) begin
			@(negedge core_clk);
			n++;
		end
		`CHK("busy level", lvl, link.busy_n)
	endtask
	task automatic start(input logic [1:0] m, input logic [1:0] s);
		wr(REG_CONTROL, {22'h0, s, 2'h0, m, 3'h0, 1'h1});
	endtask
	task automatic get_res(input logic [1:0] i, output logic [31:0] d);
		int n = 0;
		wr(REG_RESULT_SEL, {30'h0, i});
		do begin
			rd(REG_STATUS, d);
			n++;
		end while (d[STAT_READING_BIT] !== 1'b0 && n < 10);
		rd(REG_RESULT, d);
	endtask
	task automatic chk_all();
		logic [31:0] d;
		for (int i = 0; i < 4; i++) begin
			get_res(i[1:0], d);
			`CHK("result", {20'h0, exp_w[i]}, d)
		end
	endtask
	task automatic check_len(input int n);
		repeat (2) @(negedge core_clk);
		`CHK("busy cycles", n, last_len)
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		bad_count++;
		$display("wrong value watchdog exp %h got %h", 1'b0, 1'b1);
		results();
	end
	initial begin
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		rd(REG_STATUS, v);
		`CHK("status", 32'h0000_0000, v)
		rd(8'h1c, v);
		`CHK("unmapped", 32'h0000_0000, v)
		`CHK("busy idle", 1'b1, link.busy_n)
		$display("test reset done");
		repeat (8) @(posedge core_clk);
		wr(REG_IRQ_ENABLE, 32'h0000_0001);
		rd(REG_IRQ_ENABLE, v);
		`CHK("irq enable", 32'h0000_0001, v)
		foreach (rows[i]) begin
			@(posedge core_clk);
			in1 <= rows[i].v1;
			in2 <= rows[i].v2;
			in3 <= rows[i].v3;
			for (int k = 0; k < 4; k++) begin
				aux[k] <= (k == rows[i].sel) ? rows[i].va : ~rows[i].va;
			end
			start(rows[i].mode, rows[i].sel);
			wait_busy(1'b0);
			wait_busy(1'b1);
			check_len(rows[i].len);
			exp_w[1] = word(rows[i].v2);
			exp_w[2] = word(rows[i].v3);
			if (rows[i].mode[1]) exp_w[0] = word(rows[i].v1);
			if (rows[i].mode[0]) exp_w[3] = word(rows[i].va);
			`CHK("irq done", 1'b1, irq)
			chk_all();
			wr(REG_IRQ_CLEAR, 32'h0000_0001);
			repeat (2) @(negedge core_clk);
			`CHK("irq masked", 1'b0, irq)
			rd(REG_IRQ_STATUS, v);
			`CHK("irq status", 32'h0000_0002, v)
			wr(REG_IRQ_CLEAR, 32'h0000_0002);
			$display("test row %0d done", i);
		end
		@(posedge core_clk);
		in1 <= 11'h0aa;
		in2 <= 11'h6cc;
		in3 <= 11'h3f0;
		aux[0] <= 11'h111;
		start(2'h3, 2'h0);
		wait_busy(1'b0);
		repeat (30) @(negedge core_clk);
		get_res(2'h1, v);
		`CHK("old result", {20'h0, exp_w[1]}, v)
		start(2'h0, 2'h0);
		wait_busy(1'b1);
		check_len(180);
		exp_w = '{word(11'h0aa), word(11'h6cc), word(11'h3f0), word(11'h111)};
		repeat (30) @(negedge core_clk);
		`CHK("no restart", 1'b1, link.busy_n)
		chk_all();
		rd(REG_RESULT_SEL, v);
		`CHK("result select", 32'h0000_0003, v)
		$display("test double buffer done");
		start(2'h3, 2'h1);
		wait_busy(1'b0);
		repeat (50) @(negedge core_clk);
		wr(REG_CONTROL, 32'h0000_0002);
		repeat (10) @(negedge core_clk);
		`CHK("busy abort", 1'b1, link.busy_n)
		rd(REG_CONTROL, v);
		`CHK("control hold", 32'h0000_0002, v)
		wr(REG_CONTROL, 32'h0000_0000);
		repeat (10) @(negedge core_clk);
		rd(REG_STATUS, v);
		`CHK("status abort", 32'h0000_0000, v)
		exp_w = '{default: 12'h000};
		chk_all();
		$display("test chip reset done");
		results();
	end
endmodule
